/* cafc_top.sv */
// The register offsets and the Wishbone register port are this design's own decisions.
`timescale 1ns/1ps
module cafc_top import cafc_pkg::*; (
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  input wire cafc_wb_req_type wb_req_in,
  output cafc_wb_rsp_type wb_rsp_out,
  output cafc_filter_cfg_type [CAFC_NUM_FILTERS-1:0] filter_cfg_out,
  input wire logic msg_valid_in,
  input wire logic [CAFC_NUM_FILTERS-1:0] filter_hit_in,
  output cafc_accept_type accept_out
);

  cafc_top_state_type state_reg;
  cafc_top_state_type state_next;
  logic addr_hit;
  logic wr_commit;
  logic [31:0] ctrl4_value;
  cafc_filter_cfg_type [CAFC_NUM_FILTERS-1:0] cfg;
  logic [CAFC_NUM_FILTERS-1:0] enable_vec;

  // ****************************************
  // filter slots
  // ****************************************
  assign addr_hit = (wb_req_in.adr[7:2] == CAFC_CTRL4_OFFSET[7:2]);
  // a write lands on the edge where the master sees ack
  assign wr_commit = wb_req_in.cyc && wb_req_in.stb && wb_req_in.we && state_reg.rsp.ack && addr_hit;

  genvar k;
  generate
    for (k = 0; k < CAFC_NUM_FILTERS; k++) begin : g_slot
      cafc_filter_slot i_cafc_filter_slot (
        .sys_clk_in(sys_clk_in),
        .resetn_in(resetn_in),
        .wr_in(wr_commit && wb_req_in.sel[k]),
        .cfg_wr_in(cafc_filter_cfg_type'(wb_req_in.dat[k*CAFC_BYTE_W +: CAFC_BYTE_W])),
        .cfg_out(cfg[k])
      );
      assign ctrl4_value[k*CAFC_BYTE_W +: CAFC_BYTE_W] = cfg[k];
      assign enable_vec[k] = cfg[k].enable;
    end
  endgenerate

  // mask and fifo choice to the comparator
  assign filter_cfg_out = cfg;

  // ****************************************
  // bus answer and acceptance
  // ****************************************
  always_comb begin
    state_next = state_reg;
    state_next.rsp.ack = wb_req_in.cyc && wb_req_in.stb && !state_reg.rsp.ack;
    if (wb_req_in.cyc && wb_req_in.stb && !state_reg.rsp.ack) begin
      state_next.rsp.dat = addr_hit ? ctrl4_value : CAFC_UNMAPPED_READ;
    end
    state_next.acc.valid = 1'b0;
    if (msg_valid_in) begin
      // lowest numbered enabled hit wins
      for (int i = CAFC_NUM_FILTERS - 1; i >= 0; i--) begin
        if (filter_hit_in[i] && cfg[i].enable) begin
          state_next.acc.valid = 1'b1;
          state_next.acc.fifo = cfg[i].fifo_select;
          state_next.acc.filter = 5'(CAFC_FIRST_FILTER + i);
        end
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      state_reg <= CAFC_TOP_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  assign wb_rsp_out = state_reg.rsp;
  assign accept_out = state_reg.acc;

  // ****************************************
  // checks
  // ****************************************
  property p_ack_timing;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      (wb_req_in.cyc && wb_req_in.stb && !wb_rsp_out.ack) |=> wb_rsp_out.ack ##1 !wb_rsp_out.ack;
  endproperty
  a_ack_timing: assert property (p_ack_timing) else $error("ack not a single cycle after request");

  property p_accept_enabled;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      accept_out.valid |-> $past(msg_valid_in)
        && (1'($past(filter_hit_in & enable_vec) >> accept_out.filter[1:0]) == 1'b1);
  endproperty
  a_accept_enabled: assert property (p_accept_enabled) else $error("accept from a disabled filter");

  property p_disabled_silent;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      (msg_valid_in && ((filter_hit_in & {cfg[3].enable, cfg[2].enable, cfg[1].enable, cfg[0].enable}) == 4'h0))
        |=> !accept_out.valid;
  endproperty
  a_disabled_silent: assert property (p_disabled_silent) else $error("message accepted with no enabled hit");

  property p_fifo_steer;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      accept_out.valid |-> accept_out.fifo == 5'($past(ctrl4_value) >> {accept_out.filter[1:0], 3'h0});
  endproperty
  a_fifo_steer: assert property (p_fifo_steer) else $error("message steered to wrong fifo");

  property p_mask_out;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      filter_cfg_out[3].mask_select == ctrl4_value[30:29] && filter_cfg_out[0].mask_select == ctrl4_value[6:5];
  endproperty
  a_mask_out: assert property (p_mask_out) else $error("mask select does not match register");

  property p_read_f19;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      (wb_req_in.cyc && wb_req_in.stb && !wb_rsp_out.ack && addr_hit)
        |=> wb_rsp_out.dat[31] == $past(cfg[3].enable) && wb_rsp_out.dat[28:24] == $past(cfg[3].fifo_select);
  endproperty
  a_read_f19: assert property (p_read_f19) else $error("filter 19 read wrong");

  property p_read_f18;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      (wb_req_in.cyc && wb_req_in.stb && !wb_rsp_out.ack && addr_hit)
        |=> wb_rsp_out.dat[23:16] == $past(ctrl4_value[23:16]) && wb_rsp_out.dat[22:21] == $past(cfg[2].mask_select);
  endproperty
  a_read_f18: assert property (p_read_f18) else $error("filter 18 read wrong");

  property p_write_lock;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      (wr_commit && wb_req_in.sel[1] && cfg[1].enable) |=> cfg[1].fifo_select == $past(cfg[1].fifo_select);
  endproperty
  a_write_lock: assert property (p_write_lock) else $error("enabled filter 17 reconfigured");

  property p_ack_after_request;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      wb_rsp_out.ack |-> $past(wb_req_in.cyc && wb_req_in.stb);
  endproperty
  a_ack_after_request: assert property (p_ack_after_request) else $error("ack without a request");

  property p_unmapped_read;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      (wb_req_in.cyc && wb_req_in.stb && !wb_rsp_out.ack && !addr_hit) |=> wb_rsp_out.dat == CAFC_UNMAPPED_READ;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero");

  property p_unmapped_write;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      (wb_req_in.cyc && wb_req_in.stb && wb_req_in.we && !wb_rsp_out.ack && !addr_hit) |-> ##2 $stable(ctrl4_value);
  endproperty
  a_unmapped_write: assert property (p_unmapped_write) else $error("unmapped write changed settings");

  property p_read_f19_mask;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      (wb_req_in.cyc && wb_req_in.stb && !wb_rsp_out.ack && addr_hit) |=> wb_rsp_out.dat[30:29] == $past(cfg[3].mask_select);
  endproperty
  a_read_f19_mask: assert property (p_read_f19_mask) else $error("filter 19 mask read wrong");

  property p_read_f18_fields;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      (wb_req_in.cyc && wb_req_in.stb && !wb_rsp_out.ack && addr_hit)
        |=> wb_rsp_out.dat[23] == $past(cfg[2].enable) && wb_rsp_out.dat[20:16] == $past(cfg[2].fifo_select);
  endproperty
  a_read_f18_fields: assert property (p_read_f18_fields) else $error("filter 18 fields read wrong");

  property p_read_f17;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      (wb_req_in.cyc && wb_req_in.stb && !wb_rsp_out.ack && addr_hit)
        |=> wb_rsp_out.dat[15] == $past(cfg[1].enable) && wb_rsp_out.dat[14:13] == $past(cfg[1].mask_select)
          && wb_rsp_out.dat[12:8] == $past(cfg[1].fifo_select);
  endproperty
  a_read_f17: assert property (p_read_f17) else $error("filter 17 read wrong");

  property p_read_f16;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      (wb_req_in.cyc && wb_req_in.stb && !wb_rsp_out.ack && addr_hit)
        |=> wb_rsp_out.dat[7] == $past(cfg[0].enable) && wb_rsp_out.dat[6:5] == $past(cfg[0].mask_select)
          && wb_rsp_out.dat[4:0] == $past(cfg[0].fifo_select);
  endproperty
  a_read_f16: assert property (p_read_f16) else $error("filter 16 read wrong");

  property p_enable_write;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      (wr_commit && wb_req_in.sel[3]) |=> cfg[3].enable == $past(wb_req_in.dat[31]);
  endproperty
  a_enable_write: assert property (p_enable_write) else $error("filter 19 enable not written");

  property p_write_f19;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      (wr_commit && wb_req_in.sel[3] && !cfg[3].enable)
        |=> cfg[3].mask_select == $past(wb_req_in.dat[30:29]) && cfg[3].fifo_select == $past(wb_req_in.dat[28:24]);
  endproperty
  a_write_f19: assert property (p_write_f19) else $error("filter 19 write lost");

  property p_write_f18;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      (wr_commit && wb_req_in.sel[2] && !cfg[2].enable)
        |=> cfg[2].mask_select == $past(wb_req_in.dat[22:21]) && cfg[2].fifo_select == $past(wb_req_in.dat[20:16]);
  endproperty
  a_write_f18: assert property (p_write_f18) else $error("filter 18 write lost");

  property p_write_lock_f16;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      (wr_commit && wb_req_in.sel[0] && cfg[0].enable)
        |=> cfg[0].mask_select == $past(cfg[0].mask_select) && cfg[0].fifo_select == $past(cfg[0].fifo_select);
  endproperty
  a_write_lock_f16: assert property (p_write_lock_f16) else $error("enabled filter 16 reconfigured");

  property p_byte_untouched;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      !(wr_commit && wb_req_in.sel[0]) |=> $stable(cfg[0]);
  endproperty
  a_byte_untouched: assert property (p_byte_untouched) else $error("filter 16 changed without a write");

  property p_accept_pulse;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      (msg_valid_in && ((filter_hit_in & enable_vec) != 4'h0)) |=> accept_out.valid;
  endproperty
  a_accept_pulse: assert property (p_accept_pulse) else $error("enabled hit not accepted");

  property p_accept_priority;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      accept_out.valid
        |-> (($past(filter_hit_in & enable_vec) & ((4'h1 << accept_out.filter[1:0]) - 4'h1)) == 4'h0);
  endproperty
  a_accept_priority: assert property (p_accept_priority) else $error("lower numbered hit skipped");

  property p_accept_hold;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      !msg_valid_in |=> ($stable(accept_out.fifo) && $stable(accept_out.filter));
  endproperty
  a_accept_hold: assert property (p_accept_hold) else $error("accept fields moved without a message");

endmodule

/* cafc_pkg.sv */
package cafc_pkg;

  // ****************************************
  // register map and layout
  // ****************************************
  localparam logic [7:0] CAFC_CTRL4_OFFSET = 8'h00;
  localparam int CAFC_NUM_FILTERS = 4;
  localparam int CAFC_FIRST_FILTER = 16;
  localparam int CAFC_BYTE_W = 8;
  localparam int CAFC_ENABLE_POS = 7;
  localparam int CAFC_MASK_LSB = 5;
  localparam int CAFC_FIFO_LSB = 0;
  localparam logic [31:0] CAFC_CTRL4_RESET = 32'h0000_0000;
  localparam logic [31:0] CAFC_UNMAPPED_READ = 32'h0000_0000;

  // ****************************************
  // carriers
  // ****************************************
  // one filter byte: enable at bit 7, mask select 6:5, fifo select 4:0
  typedef struct packed {
    logic enable;
    logic [1:0] mask_select;
    logic [4:0] fifo_select;
  } cafc_filter_cfg_type;

  localparam cafc_filter_cfg_type CAFC_FILTER_RESET = '{enable: 1'b0, mask_select: 2'h0, fifo_select: 5'h00};

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } cafc_wb_req_type;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } cafc_wb_rsp_type;

  typedef struct packed {
    logic valid;
    logic [4:0] fifo;
    logic [4:0] filter;
  } cafc_accept_type;

  // ****************************************
  // module state
  // ****************************************
  typedef struct packed {
    cafc_filter_cfg_type cfg;
  } cafc_slot_state_type;

  localparam cafc_slot_state_type CAFC_SLOT_RESET = '{cfg: CAFC_FILTER_RESET};

  typedef struct packed {
    cafc_wb_rsp_type rsp;
    cafc_accept_type acc;
  } cafc_top_state_type;

  localparam cafc_top_state_type CAFC_TOP_RESET = '{
    rsp: '{ack: 1'b0, dat: CAFC_CTRL4_RESET},
    acc: '{valid: 1'b0, fifo: 5'h00, filter: 5'h00}
  };

endpackage

/* cafc_filter_slot.sv */
`timescale 1ns/1ps
module cafc_filter_slot import cafc_pkg::*; (
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  input wire logic wr_in,
  input wire cafc_filter_cfg_type cfg_wr_in,
  output cafc_filter_cfg_type cfg_out
);

  cafc_slot_state_type state_reg;
  cafc_slot_state_type state_next;

  // ****************************************
  // settings byte
  // ****************************************
  always_comb begin
    state_next = state_reg;
    if (wr_in) begin
      state_next.cfg.enable = cfg_wr_in.enable;
      if (!state_reg.cfg.enable) begin
        state_next.cfg.mask_select = cfg_wr_in.mask_select;
        state_next.cfg.fifo_select = cfg_wr_in.fifo_select;
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      state_reg <= CAFC_SLOT_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  assign cfg_out = state_reg.cfg;

  // ****************************************
  // checks
  // ****************************************
  property p_locked_fields;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      cfg_out.enable |=> ($stable(cfg_out.mask_select) && $stable(cfg_out.fifo_select));
  endproperty
  a_locked_fields: assert property (p_locked_fields) else $error("fields changed while enabled");

  property p_unlocked_write;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      (wr_in && !cfg_out.enable) |=> (cfg_out == $past(cfg_wr_in));
  endproperty
  a_unlocked_write: assert property (p_unlocked_write) else $error("write to disabled filter lost");

  property p_reset_clear;
    @(posedge sys_clk_in) !resetn_in |=> (cfg_out == CAFC_FILTER_RESET);
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("filter not cleared by reset");

endmodule

/* cafc_can_model.sv */
`timescale 1ns/1ps
module cafc_can_model import cafc_pkg::*; (
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  input wire logic send_in,
  input wire logic [CAFC_NUM_FILTERS-1:0] hits_in,
  output logic msg_valid_out,
  output logic [CAFC_NUM_FILTERS-1:0] filter_hit_out
);
  // hit lines only mean something beside the valid pulse; toggle them otherwise
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      msg_valid_out <= 1'b0;
      filter_hit_out <= 4'h0;
    end else begin
      msg_valid_out <= send_in;
      filter_hit_out <= send_in ? hits_in : ~filter_hit_out;
    end
  end
endmodule

/* cafc_top_tb.sv */
`timescale 1ns/1ps
module cafc_top_tb import cafc_pkg::*; ;
  logic sys_clk_in = 1'b0;
  logic resetn_in = 1'b0;
  cafc_wb_req_type wb_req = '0;
  cafc_wb_rsp_type wb_rsp;
  cafc_filter_cfg_type [CAFC_NUM_FILTERS-1:0] cfg;
  cafc_accept_type acc;
  logic send = 1'b0;
  logic [3:0] hits = 4'h0;
  logic msg_valid;
  logic [3:0] filter_hit;
  logic [31:0] rd;
  int n_errors = 0;
  int checks_done = 0;

  cafc_top i_cafc_top (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .wb_req_in(wb_req), .wb_rsp_out(wb_rsp),
    .filter_cfg_out(cfg), .msg_valid_in(msg_valid), .filter_hit_in(filter_hit), .accept_out(acc));
  cafc_can_model i_cafc_can_model (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .send_in(send),
    .hits_in(hits), .msg_valid_out(msg_valid), .filter_hit_out(filter_hit));

  initial begin
    forever #5 sys_clk_in = ~sys_clk_in;
  end

  task automatic conclude();
    if (n_errors == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one classic cycle, entered just after a rising edge
  task automatic wb(input logic we, input logic [7:0] adr, input logic [3:0] sel, input logic [31:0] dat);
    int i;
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: sel, dat: dat};
    for (i = 0; i < 20 && wb_rsp.ack !== 1'b1; i++) @(posedge sys_clk_in);
    if (i == 20) begin
      n_errors++;
      conclude();
    end
    rd = wb_rsp.dat;
    wb_req.cyc <= 1'b0;
    wb_req.stb <= 1'b0;
    @(posedge sys_clk_in);
  endtask

  task automatic msg(input logic [3:0] h, input int pulses, input logic [9:0] exp);
    int n;
    logic [9:0] got;
    n = 0;
    got = 10'h000;
    send <= 1'b1;
    hits <= h;
    @(posedge sys_clk_in);
    send <= 1'b0;
    repeat (4) begin
      @(posedge sys_clk_in);
      if (acc.valid === 1'b1) begin
        n++;
        got = {acc.filter, acc.fifo};
      end
    end
    chk(n, pulses);
    if (pulses > 0) chk(got, exp);
  endtask

  initial begin
    repeat (5000) @(posedge sys_clk_in);
    n_errors++;
    conclude();
  end

  initial begin
    repeat (2) @(posedge sys_clk_in);
    resetn_in <= 1'b1;
    @(posedge sys_clk_in);
    chk(cfg, 32'h0);
    wb(1'b0, CAFC_CTRL4_OFFSET, 4'hf, 32'h0);
    chk(rd, 32'h0);
    wb(1'b1, CAFC_CTRL4_OFFSET, 4'hf, 32'h7f5a3c1f);
    chk(cfg, 32'h7f5a3c1f);
    wb(1'b0, CAFC_CTRL4_OFFSET, 4'hf, 32'h0);
    chk(rd, 32'h7f5a3c1f);
    wb(1'b1, CAFC_CTRL4_OFFSET, 4'hf, 32'hffdabc9f);
    wb(1'b1, CAFC_CTRL4_OFFSET, 4'hf, 32'h80808080);
    wb(1'b0, CAFC_CTRL4_OFFSET, 4'hf, 32'h0);
    chk(rd, 32'hffdabc9f);
    chk(cfg, 32'hffdabc9f);
    wb(1'b1, CAFC_CTRL4_OFFSET, 4'h1, 32'h00000000);
    wb(1'b1, CAFC_CTRL4_OFFSET, 4'h1, 32'h00000005);
    wb(1'b0, CAFC_CTRL4_OFFSET, 4'hf, 32'h0);
    chk(rd, 32'hffdabc05);
    wb(1'b1, 8'h04, 4'hf, 32'hffffffff);
    wb(1'b0, 8'h04, 4'hf, 32'h0);
    chk(rd, CAFC_UNMAPPED_READ);
    chk(cfg, 32'hffdabc05);
    msg(4'h1, 0, 10'h000);
    msg(4'hf, 1, {5'h11, 5'h1c});
    msg(4'h8, 1, {5'h13, 5'h1f});
    msg(4'h4, 1, {5'h12, 5'h1a});
    resetn_in <= 1'b0;
    repeat (2) @(posedge sys_clk_in);
    resetn_in <= 1'b1;
    @(posedge sys_clk_in);
    chk(cfg, 32'h0);
    chk({21'h0, acc}, 32'h0);
    wb(1'b0, CAFC_CTRL4_OFFSET, 4'hf, 32'h0);
    chk(rd, CAFC_CTRL4_RESET);
    conclude();
  end
endmodule
